// ===== src/dpw_map.svh
// Offsets, field positions, reset values and wait counts of the DRAM
// page and wait-state controller. Definitions only; include by bare name.
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH

// Register byte offsets on the AHB-Lite port (low 8 address bits)
`define DPW_OFF_CFG 8'h00
`define DPW_OFF_STAT 8'h04

// Configuration reset value and write mask (reserved bits 10, 7:4)
`define DPW_CFG_RST 24'h000000
`define DPW_CFG_WMASK 24'hfffb0f

// Field positions inside dram_config_reg
`define DPW_POS_SOFT_REF 14
`define DPW_POS_KEEP 12
`define DPW_POS_PLE 11
`define DPW_POS_PSEL 8
`define DPW_POS_RWS 2
`define DPW_POS_CWS 0

// Status register field positions
`define DPW_POS_ST_BUSY 0
`define DPW_POS_ST_PGV 1
`define DPW_POS_ST_BANK 2
`define DPW_POS_ST_REFP 4

// Smallest column width, in address bits
`define DPW_COL_BASE 5'd9

// Out-of-page wait states per row_wait_select code
`define DPW_RW0 4'd4
`define DPW_RW1 4'd8
`define DPW_RW2 4'd11
`define DPW_RW3 4'd15

// In-page wait states per column_wait_select code
`define DPW_CW0 4'd1
`define DPW_CW1 4'd2
`define DPW_CW2 4'd3
`define DPW_CW3 4'd4

`endif

// ===== src/dpw_pkg.sv
// Types of the DRAM page and wait-state controller.
// Assumes dpw_map.svh for all numeric constants.
package dpw_pkg;

    // Controller sequence states
    typedef enum logic [2:0] {
        S_IDLE, S_ROW, S_COL, S_PAGE, S_RQ, S_RCAS, S_RRAS
    } dpw_state_e;

    // Layout of dram_config_reg, bit 23 first
    typedef struct packed {
        logic rate_pre;
        logic [7:0] rate;
        logic soft_refresh_request;
        logic refresh_en;
        logic mastership_keep_drive;
        logic page_logic_enable;
        logic rsv10;
        logic [1:0] page_size_select;
        logic [3:0] rsv7_4;
        logic [1:0] row_wait_select;
        logic [1:0] column_wait_select;
    } dpw_cfg_s;

    // One DRAM access request: word address and area strobe index
    typedef struct packed {
        logic [23:0] addr;
        logic [1:0] bank;
    } dpw_acc_s;

    // Whole state of the controller
    typedef struct packed {
        dpw_state_e st;
        dpw_cfg_s cfg;
        logic [3:0] cnt;
        dpw_acc_s a;
        logic pg_valid;
        logic [1:0] pg_bank;
        logic [23:0] pg_tag;
        logic [3:0] ras_n;
        logic cas_n;
        logic [23:0] xa;
        logic done;
        logic ref_pend;
        logic wr_pend;
        logic [7:0] wa;
        logic [31:0] rdata;
    } dpw_st_s;

endpackage

// ===== src/dpw_addr_mux.sv
// Row/column address multiplexer and page mask for the DRAM port.
// Assumes a 24-bit word address and a column width of 9 to 12 bits.
`timescale 1ns/10ps
module dpw_addr_mux
    import dpw_pkg::*;
(
    input wire logic [23:0] addr,
    input wire logic [1:0] psel,
    output logic [23:0] row_a,
    output logic [23:0] col_a,
    output logic [23:0] row_mask
);
    `include "dpw_map.svh"

    // Column width from page size code: 9, 10, 11 or 12
    logic [4:0] cw;
    assign cw = `DPW_COL_BASE + {3'h0, psel}; // RULE8

    // Per bit: the low lines carry the address bits above the column
    // width, and the top lines keep the upper address bits in place,
    // so all 24 lines are driven in the row phase
    for (genvar i = 0; i < 24; i++) begin : g_bit
        logic [5:0] sum;
        logic [5:0] idx;
        assign sum = 6'(i) + {1'b0, cw};
        assign idx = (sum >= 6'h18) ? 6'(i) : sum;
        assign row_a[i] = addr[idx[4:0]]; // RULE10
        // Column phase carries only the low bits
        assign col_a[i] = (5'(i) < cw) ? addr[i] : 1'b0; // RULE8
        // Bits above the column width identify the page
        assign row_mask[i] = (5'(i) >= cw); // RULE16
    end

endmodule // dpw_addr_mux

// ===== src/dpw_ctrl.sv
// DRAM page-hit, strobe and wait-state controller with AHB-Lite access
// to its configuration. Assumes one external refresh-rate counter that
// pulses refresh_tick, and an arbiter that reports bus mastership.
//
// Notes on behaviour
// (RULE1) Keep clear, mastership lost: strobes float
// (RULE2) Keep clear, mastership lost: next access misses
// (RULE3) Hold mastership before refresh unless keep set
// (RULE4) Keep set: strobes always driven, refresh anytime
// (RULE5) In-page hit drives column address and strobe
// (RULE6) Page logic off: every access out-of-page
// (RULE7) One tracker; other bank means page miss
// (RULE8) Page size code selects 9 to 12 columns
// (RULE9) Page size used only with page logic; code also uses it for the row/column split
// (RULE10) Row phase drives all 24 address lines
// (RULE11) Row wait code gives 4/8/11/15 waits
// (RULE12) Column wait code gives 1/2/3/4 waits
// (RULE13) Software writes reserved bits as zero
// (RULE14) Refresh lasts as long as out-of-page access
// (RULE15) Software keeps config stable during accesses
// (RULE16) Hit needs equal upper bits, same bank
`timescale 1ns/10ps
module dpw_ctrl
    import dpw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Access request side
    input wire logic acc_req,
    input wire dpw_acc_s acc,
    output logic acc_ack,
    output logic acc_done,
    output logic busy,
    // Refresh and bus mastership
    input wire logic refresh_tick,
    input wire logic bus_master,
    output logic bus_req,
    // DRAM pins
    output logic [23:0] ext_addr,
    output logic [3:0] ras_n,
    output logic cas_n,
    output logic strobe_oe
);
    `include "dpw_map.svh"

    // Registered state and its next value
    dpw_st_s s_r;
    dpw_st_s s_nxt;

    // Address phase accepted by this slave
    logic aphase;
    // Refresh wanted by timer or software
    logic rq;
    // Shorthand for the mastership keep-drive bit
    logic keep;
    // Access taken this cycle and whether it hits the open page
    logic start;
    logic hit;
    // Wait counts decoded from the configuration
    logic [3:0] rw_cnt;
    logic [3:0] cw_cnt;
    // Multiplexer outputs for the address in use
    logic [23:0] mux_in;
    logic [23:0] row_a;
    logic [23:0] col_a;
    logic [23:0] row_mask;
    logic [31:0] stat;

    assign keep = s_r.cfg.mastership_keep_drive;
    assign rq = s_r.ref_pend | s_r.cfg.soft_refresh_request;
    assign aphase = hsel & hready & htrans[1];

    // Out-of-page wait count lookup
    always_comb begin
        unique case (s_r.cfg.row_wait_select)
            2'h0: rw_cnt = `DPW_RW0; // RULE11
            2'h1: rw_cnt = `DPW_RW1; // RULE11
            2'h2: rw_cnt = `DPW_RW2; // RULE11
            2'h3: rw_cnt = `DPW_RW3; // RULE11
        endcase
    end

    // In-page wait count lookup
    always_comb begin
        unique case (s_r.cfg.column_wait_select)
            2'h0: cw_cnt = `DPW_CW0; // RULE12
            2'h1: cw_cnt = `DPW_CW1; // RULE12
            2'h2: cw_cnt = `DPW_CW2; // RULE12
            2'h3: cw_cnt = `DPW_CW3; // RULE12
        endcase
    end

    // While idle the mux looks at the incoming request, later at the
    // latched one, so ext_addr is loaded at the same edge that enters each phase
    assign mux_in = (s_r.st == S_IDLE) ? acc.addr : s_r.a.addr;

    dpw_addr_mux u_mux (
        .addr(mux_in),
        .psel(s_r.cfg.page_size_select),
        .row_a(row_a),
        .col_a(col_a),
        .row_mask(row_mask)
    );

    // Page hit only with page logic on, open page, same bank and
    // equal upper address bits; page size also sets the row/column address split
    assign hit = s_r.cfg.page_logic_enable & s_r.pg_valid // RULE6 RULE9
        & (acc.bank == s_r.pg_bank) // RULE7
        & (((acc.addr ^ s_r.pg_tag) & row_mask) == 24'h000000); // RULE16

    // A refresh request outranks a waiting access
    assign start = (s_r.st == S_IDLE) & ~rq & acc_req & bus_master;

    // Status word: busy, open page, its bank, refresh pending
    always_comb begin
        stat = 32'h00000000;
        stat[`DPW_POS_ST_BUSY] = (s_r.st != S_IDLE);
        stat[`DPW_POS_ST_PGV] = s_r.pg_valid;
        stat[`DPW_POS_ST_BANK +: 2] = s_r.pg_bank;
        stat[`DPW_POS_ST_REFP] = rq;
    end

    // Next state: sequencer, then refresh request, then bus writes
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            S_IDLE: begin
                if (rq) begin
                    // Without keep-drive the bus must be won first
                    s_nxt.st = keep ? S_RCAS : S_RQ; // RULE3 RULE4
                    if (keep) begin
                        s_nxt.cas_n = 1'b0;
                        s_nxt.ras_n = 4'hf;
                        s_nxt.pg_valid = 1'b0;
                    end
                end else if (start) begin
                    s_nxt.a = acc;
                    if (hit) begin
                        // Open page: column address and strobe only
                        s_nxt.st = S_PAGE; // RULE5
                        s_nxt.xa = col_a; // RULE5
                        s_nxt.cas_n = 1'b0; // RULE5
                        s_nxt.cnt = cw_cnt; // RULE12
                    end else begin
                        // Miss: close every row, then a row phase
                        s_nxt.st = S_ROW; // RULE6 RULE7
                        s_nxt.xa = row_a; // RULE10
                        s_nxt.ras_n = 4'hf;
                        s_nxt.pg_valid = 1'b0;
                    end
                end
            end
            S_ROW: begin
                // Row strobe of the addressed bank, column next
                s_nxt.ras_n = ~(4'h1 << s_r.a.bank);
                s_nxt.st = S_COL;
                s_nxt.xa = col_a;
                s_nxt.cas_n = 1'b0;
                s_nxt.cnt = rw_cnt; // RULE11
            end
            S_COL, S_PAGE: begin
                if (s_r.cnt == 4'h0) begin
                    s_nxt.st = S_IDLE;
                    s_nxt.cas_n = 1'b1;
                    s_nxt.done = 1'b1;
                    if (s_r.cfg.page_logic_enable) begin
                        // Leave the row open for later hits
                        s_nxt.pg_valid = 1'b1;
                        s_nxt.pg_bank = s_r.a.bank;
                        s_nxt.pg_tag = s_r.a.addr;
                    end else begin
                        // Low power: close the row at once
                        s_nxt.ras_n = 4'hf; // RULE6
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            S_RQ: begin
                // Hold here asking for the bus until it is granted or keep is set
                if (bus_master | keep) begin // RULE3
                    s_nxt.st = S_RCAS;
                    s_nxt.cas_n = 1'b0;
                    s_nxt.ras_n = 4'hf;
                    s_nxt.pg_valid = 1'b0;
                end
            end
            S_RCAS: begin
                // Column before row: every bank strobed together
                s_nxt.st = S_RRAS;
                s_nxt.ras_n = 4'h0;
                s_nxt.cnt = rw_cnt; // RULE14
            end
            S_RRAS: begin
                if (s_r.cnt == 4'h0) begin
                    s_nxt.st = S_IDLE;
                    s_nxt.ras_n = 4'hf;
                    s_nxt.cas_n = 1'b1;
                    s_nxt.ref_pend = 1'b0;
                    s_nxt.cfg.soft_refresh_request = 1'b0;
                end else begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
        endcase
        // Lost bus without keep-drive: open page can no longer be trusted
        if (!keep && !bus_master) begin
            s_nxt.pg_valid = 1'b0; // RULE2
        end
        // A tick in the clearing cycle survives: set wins
        if (refresh_tick) begin
            s_nxt.ref_pend = 1'b1;
        end
        // Data phase of a write; reserved bits are stored as zero so a
        // careless write cannot leak into later devices' fields
        if (s_r.wr_pend && s_r.wa == `DPW_OFF_CFG) begin
            s_nxt.cfg = dpw_cfg_s'(hwdata[23:0] & `DPW_CFG_WMASK);
            // A pending soft refresh is not dropped by the same write
            if (s_r.cfg.soft_refresh_request
                && s_nxt.cfg.soft_refresh_request == 1'b0
                && s_r.st != S_RRAS) begin
                s_nxt.cfg.soft_refresh_request = 1'b1;
            end
        end
        s_nxt.wr_pend = aphase & hwrite;
        s_nxt.wa = haddr[7:0];
        // Read data is fetched in the address phase; a read straight
        // after a write to the same register sees the old value
        if (aphase && !hwrite) begin
            unique case (haddr[7:0])
                `DPW_OFF_CFG: s_nxt.rdata = {8'h00, s_r.cfg};
                `DPW_OFF_STAT: s_nxt.rdata = stat;
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{st: S_IDLE, cfg: dpw_cfg_s'(`DPW_CFG_RST),
                ras_n: 4'hf, cas_n: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bus answers: zero-wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;

    // Request side and pins
    assign acc_ack = start;
    assign acc_done = s_r.done;
    assign busy = (s_r.st != S_IDLE);
    assign bus_req = (s_r.st == S_RQ);
    assign ext_addr = s_r.xa;
    assign ras_n = s_r.ras_n;
    assign cas_n = s_r.cas_n;
    // Strobes float only when neither kept nor bus master
    assign strobe_oe = keep | bus_master; // RULE1 RULE4

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_strobe_float: assert property ( // RULE1
        (!keep && !bus_master) |-> !strobe_oe)
        else $error("strobes driven after mastership loss");

    a_miss_after_loss: assert property ( // RULE2
        (!keep && !bus_master) |=> !s_r.pg_valid)
        else $error("page kept open after mastership loss");

    a_refresh_waits_bus: assert property ( // RULE3
        (s_r.st == S_RQ && !bus_master && !keep) |=> s_r.st == S_RQ)
        else $error("refresh started without mastership");

    a_keep_drives: assert property ( // RULE4
        keep |-> strobe_oe)
        else $error("strobes not driven with keep set");

    a_hit_column: assert property ( // RULE5
        (start && hit) |=> (s_r.st == S_PAGE && !cas_n
            && ext_addr == col_a && $stable(ras_n)))
        else $error("in-page access not column only");

    a_page_off_miss: assert property ( // RULE6
        (start && !s_r.cfg.page_logic_enable) |=> s_r.st == S_ROW)
        else $error("page hit with page logic disabled");

    a_bank_switch: assert property ( // RULE7
        (start && acc.bank != s_r.pg_bank) |=> s_r.st == S_ROW)
        else $error("bank switch not treated as miss");

    a_row_lines: assert property ( // RULE10
        (s_r.st == S_ROW) |-> ext_addr == row_a)
        else $error("row phase address wrong");

    a_row_wait: assert property ( // RULE11
        (s_r.st == S_ROW) |=> s_r.cnt == rw_cnt
            ##1 (s_r.st == S_COL) [*1] ##0 !cas_n)
        else $error("out-of-page wait count wrong");

    a_col_wait: assert property ( // RULE12
        (s_r.st == S_PAGE && $past(s_r.st) == S_IDLE)
            |-> s_r.cnt == cw_cnt)
        else $error("in-page wait count wrong");

    a_refresh_len: assert property ( // RULE14
        (s_r.st == S_RCAS) |=> (s_r.st == S_RRAS && s_r.cnt == rw_cnt
            && ras_n == 4'h0 && !cas_n))
        else $error("refresh length wrong");

    // Page compared by shifting, independent of the mux mask
    a_hit_upper: assert property ( // RULE9 RULE16
        (start && hit) |-> ((acc.addr >> (`DPW_COL_BASE
            + s_r.cfg.page_size_select)) == (s_r.pg_tag >> (`DPW_COL_BASE
            + s_r.cfg.page_size_select))))
        else $error("hit with different page");

    // A row phase strobes exactly the addressed bank
    a_miss_row_strobe: assert property ( // RULE6
        (s_r.st == S_ROW) |=> (ras_n[s_r.a.bank] == 1'b0
            && $countones(~ras_n) == 1))
        else $error("row strobe not on the addressed bank");

    // Without keep-drive the whole refresh runs as bus master; this
    // relies on the arbiter not taking the bus back mid-refresh
    a_refresh_master: assert property ( // RULE3
        (s_r.st inside {S_RCAS, S_RRAS} && !keep) |-> bus_master)
        else $error("refresh run without mastership");

endmodule // dpw_ctrl

// ===== verif/dpw_dram_model.sv
// Far side of the DRAM port: strobe pins with pull-ups and a bus
// arbiter that can hand mastership to another master on command.
// Assumes the bench drives take_bus and watches the resolved pins.
`timescale 1ns/10ps
module dpw_dram_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic take_bus,
    input wire logic bus_req,
    input wire logic [3:0] ras_n,
    input wire logic cas_n,
    input wire logic strobe_oe,
    output logic bus_master,
    output logic [3:0] ras_pin,
    output logic cas_pin
);
    logic [1:0] wait_r; // Cycles the request has waited for a grant
    logic [4:0] hold_r; // Grant hold time once given

    // Released strobes float up to the pull-up level
    assign ras_pin = strobe_oe ? ras_n : 4'hf;
    assign cas_pin = strobe_oe ? cas_n : 1'b1;

    // Slow arbiter: a request from the device waits four cycles, and
    // the grant is then held long enough for a whole refresh
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r <= 2'd0;
            hold_r <= 5'd0;
            bus_master <= 1'b1;
        end else begin
            wait_r <= (bus_req && !bus_master) ? wait_r + 2'd1 : 2'd0;
            if (bus_req && wait_r == 2'd3) begin
                hold_r <= 5'd31;
            end else begin
                hold_r <= hold_r - {4'h0, hold_r != 5'd0};
            end
            bus_master <= !take_bus || hold_r != 5'd0 ||
                (bus_req && wait_r == 2'd3);
        end
    end
endmodule // dpw_dram_model

// ===== verif/tb_top.sv
// Self-checking bench of the DRAM page and wait-state controller.
// Assumes dpw_ctrl as the device and dpw_dram_model as the far side.
`timescale 1ns/10ps
`include "dpw_map.svh"
module tb_top;
    import dpw_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic acc_req, acc_ack, acc_done, busy, refresh_tick, take_bus;
    dpw_acc_s acc;
    logic bus_master, bus_req, cas_n, strobe_oe, cas_pin;
    logic [23:0] ext_addr;
    logic [3:0] ras_n, ras_pin;
    int miscompares, samples_checked;
    int rw_tab[4] = '{4, 8, 11, 15}; // Out-of-page waits per code
    int cw_tab[4] = '{1, 2, 3, 4}; // In-page waits per code

    dpw_ctrl u_dpw_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .acc_req(acc_req), .acc(acc),
        .acc_ack(acc_ack), .acc_done(acc_done), .busy(busy),
        .refresh_tick(refresh_tick), .bus_master(bus_master),
        .bus_req(bus_req), .ext_addr(ext_addr), .ras_n(ras_n),
        .cas_n(cas_n), .strobe_oe(strobe_oe));
    dpw_dram_model u_dpw_dram_model (.hclk(hclk), .hresetn(hresetn),
        .take_bus(take_bus), .bus_req(bus_req), .ras_n(ras_n),
        .cas_n(cas_n), .strobe_oe(strobe_oe), .bus_master(bus_master),
        .ras_pin(ras_pin), .cas_pin(cas_pin));

    // Compare one value and count it
    task chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %0h exp %0h", $time, what,
                got, exp);
        end
    endtask

    // One single AHB-Lite transfer; waits on hready in both phases
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        chk({31'h0, hresp}, 32'h0, "response code");
    endtask

    // Configuration is only written between accesses
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(x, e, w);
    endtask

    // Config word with reserved bits left zero
    function automatic logic [31:0] mk(input logic keep, input logic ple,
        input logic [1:0] ps, input logic [1:0] rw, input logic [1:0] cw);
        mk = 32'h0;
        mk[12] = keep;
        mk[11] = ple;
        mk[9:8] = ps;
        mk[3:2] = rw;
        mk[1:0] = cw;
    endfunction

    // Run one access; n counts cycles from the taking edge to done
    task acc_run(input logic [23:0] a, input logic [1:0] b, output int n,
        output logic [23:0] row);
        int k;
        @(posedge hclk);
        acc_req <= 1'b1;
        acc <= '{addr: a, bank: b};
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while (acc_ack !== 1'b1 && k < 100);
        @(posedge hclk);
        acc_req <= 1'b0;
        n = 0;
        row = 24'h0;
        do begin
            @(negedge hclk);
            n++;
            if (n == 1) row = ext_addr;
        end while (acc_done !== 1'b1 && n < 100);
    endtask

    task acc_chk(input logic [23:0] a, input logic [1:0] b, input int e);
        int n;
        logic [23:0] row;
        acc_run(a, b, n, row);
        chk(n, e, "access length");
    endtask

    // Length of a refresh (all row strobes low) and mastership then
    task ref_len(output int n, output logic m);
        int k;
        k = 0;
        while (ras_pin !== 4'h0 && k < 200) begin
            @(negedge hclk);
            k++;
        end
        m = bus_master;
        n = 0;
        while (ras_pin === 4'h0 && n < 100) begin
            @(negedge hclk);
            n++;
        end
    endtask

    // Reset values, reserved bits and an unmapped offset
    task t_regs();
        chk({26'h0, busy, ras_n, cas_n}, 32'h1f, "pins after reset");
        rd_chk(`DPW_OFF_CFG, 32'h0, "config reset");
        wr(`DPW_OFF_CFG, 32'h00001ff3);
        rd_chk(`DPW_OFF_CFG, 32'h00001b03, "reserved bits");
        wr(8'h08, 32'h0000000f);
        rd_chk(8'h08, 32'h0, "unmapped read");
        rd_chk(`DPW_OFF_CFG, 32'h00001b03, "unmapped write");
    endtask

    // Page logic off: repeats still miss, for every row wait code
    task t_miss();
        for (int r = 0; r < 4; r++) begin
            wr(`DPW_OFF_CFG, mk(1'b0, 1'b0, r[1:0], r[1:0], 2'd3));
            acc_chk(24'h001234, 2'd3, rw_tab[r] + 3);
            acc_chk(24'h001234, 2'd3, rw_tab[r] + 3);
        end
    endtask

    // Page size edge: top column bit hits, next bit up misses
    task t_psel();
        logic [23:0] a, row, erow;
        int n;
        a = 24'h5a5a5a;
        for (int p = 0; p < 4; p++) begin
            wr(`DPW_OFF_CFG, mk(1'b0, 1'b1, p[1:0], 2'd0, 2'd0));
            acc_run(a, p[1:0], n, row);
            chk(n, 7, "new bank miss");
            // Upper bits on the low lines, top lines keep the upper bits
            erow = (a >> (9 + p)) | (a & ~(24'hffffff >> (9 + p)));
            chk(row, erow, "row");
            acc_chk(a ^ (24'h1 << (8 + p)), p[1:0], 3);
            acc_chk(a ^ (24'h1 << (9 + p)), p[1:0], 7);
        end
    endtask

    // In-page waits for every column code, then a bank switch
    task t_hit();
        logic [23:0] a;
        for (int c = 0; c < 4; c++) begin
            a = {6'h02, c[1:0], 16'h0000};
            wr(`DPW_OFF_CFG, mk(1'b0, 1'b1, 2'd1, 2'd0, c[1:0]));
            acc_chk(a, 2'd1, 7);
            acc_chk(a + 24'h1, 2'd1, cw_tab[c] + 2);
            acc_chk(a + 24'h1, 2'd2, 7);
        end
    endtask

    // Mastership lost: strobes float and the open page is dropped
    task t_master();
        wr(`DPW_OFF_CFG, mk(1'b0, 1'b1, 2'd0, 2'd0, 2'd0));
        acc_chk(24'h030303, 2'd0, 7);
        acc_chk(24'h030303, 2'd0, 3);
        rd_chk(`DPW_OFF_STAT, 32'h2, "status open page");
        @(posedge hclk);
        take_bus <= 1'b1;
        repeat (3) @(negedge hclk);
        chk({26'h0, strobe_oe, ras_pin, cas_pin}, 32'h1f, "float");
        @(posedge hclk);
        take_bus <= 1'b0;
        acc_chk(24'h030303, 2'd0, 7);
        wr(`DPW_OFF_CFG, mk(1'b1, 1'b1, 2'd0, 2'd0, 2'd0));
        @(posedge hclk);
        take_bus <= 1'b1;
        repeat (3) @(negedge hclk);
        chk({31'h0, strobe_oe}, 32'h1, "kept driven");
        @(posedge hclk);
        take_bus <= 1'b0;
    endtask

    // Software refresh needs the bus; tick refresh with keep does not
    task t_refresh();
        int n;
        logic m;
        wr(`DPW_OFF_CFG, mk(1'b0, 1'b0, 2'd0, 2'd1, 2'd0));
        @(posedge hclk);
        take_bus <= 1'b1;
        wr(`DPW_OFF_CFG, mk(1'b0, 1'b0, 2'd0, 2'd1, 2'd0) | 32'h4000);
        repeat (2) @(negedge hclk);
        chk({29'h0, busy, bus_req, bus_master}, 32'h6, "bus asked");
        ref_len(n, m);
        chk(n, rw_tab[1] + 1, "refresh length");
        chk({31'h0, m}, 32'h1, "master in refresh");
        rd_chk(`DPW_OFF_CFG, mk(1'b0, 1'b0, 2'd0, 2'd1, 2'd0), "bit clr");
        wr(`DPW_OFF_CFG, mk(1'b1, 1'b0, 2'd0, 2'd0, 2'd0) | 32'h2000);
        repeat (32) @(posedge hclk);
        refresh_tick <= 1'b1;
        @(posedge hclk);
        refresh_tick <= 1'b0;
        ref_len(n, m);
        chk(n, rw_tab[0] + 1, "tick refresh length");
        chk({31'h0, m}, 32'h0, "refresh not master");
        wr(`DPW_OFF_CFG, 32'h0);
        take_bus <= 1'b0;
    endtask

    // Single place where the run ends
    task give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Hang guard at 10000 cycles, far beyond the few hundred cycles the tests take
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, acc_req, refresh_tick, take_bus} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        acc = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_miss();
        t_psel();
        t_hit();
        t_master();
        t_refresh();
        give_verdict();
    end
endmodule // tb_top
